// file: src/add_and_latch_read_datapath.sv
// Operation
// - Add-literal opcode adds accumulator and 8-bit literal into accumulator.
// - Add-register opcode adds accumulator and file register; d clear writes accumulator.
// - Add-register with d set writes the file register, accumulator unchanged.
// - Latch-read copies one table latch byte into the addressed file register.
// - Byte select 1 copies the high latch byte, 0 the low byte.
// - Latch-read changes neither latch byte nor any status flag.
// - Latch-read returns bytes loaded earlier by the program table read.
`timescale 1ns/100ps
module add_and_latch_read_datapath (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Instruction from the decoder, taken in the decode phase.
    input wire add_latch_pkg::instr_t instr,
    output logic instr_ready,
    // Table latch, loaded by the program table read elsewhere in the core.
    input wire logic [15:0] table_latch,
    // File register array.
    output add_latch_pkg::file_req_t file_req,
    input wire logic [7:0] file_rdata,
    // Results.
    output logic [7:0] working_accumulator,
    output logic op_done
);

    // ==========================================================
    // State
    // ==========================================================
    add_latch_pkg::state_t st_ff;
    add_latch_pkg::state_t nxt_st;
    logic [15:0] latch_snap;

    // The decoder may only present a new word while we sit in decode.
    assign instr_ready = (st_ff.phase == add_latch_pkg::PH_DECODE);
    assign latch_snap = table_latch;

    // Next-state logic walks the four phases of one instruction cycle.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.file.rd_en = 1'b0;
        nxt_st.file.wr_en = 1'b0;
        case (st_ff.phase)
            add_latch_pkg::PH_DECODE: begin
                nxt_st.op = add_latch_pkg::OP_NONE;
                nxt_st.word = instr.word;
                nxt_st.phase = add_latch_pkg::PH_DECODE;
                if (instr.valid) begin
                    nxt_st.phase = add_latch_pkg::PH_READ;
                    nxt_st.file.addr = instr.word[7:0];
                    if (instr.word[15:8] == add_latch_pkg::OPC_ADD_LITERAL) begin
                        nxt_st.op = add_latch_pkg::OP_ADD_LIT;
                    end else if (instr.word[15:9] == add_latch_pkg::OPC_ADD_REGISTER) begin
                        nxt_st.op = add_latch_pkg::OP_ADD_REG;
                        nxt_st.file.rd_en = 1'b1;
                    end else if (instr.word[15:10] == add_latch_pkg::OPC_LATCH_READ) begin
                        nxt_st.op = add_latch_pkg::OP_LATCH_RD;
                    end
                end
            end
            add_latch_pkg::PH_READ: begin
                nxt_st.phase = add_latch_pkg::PH_PROCESS;
                case (st_ff.op)
                    add_latch_pkg::OP_ADD_LIT: nxt_st.operand = st_ff.word[7:0];
                    // Array answers in the same cycle as the read strobe.
                    add_latch_pkg::OP_ADD_REG: nxt_st.operand = file_rdata;
                    add_latch_pkg::OP_LATCH_RD: begin
                        if (st_ff.word[add_latch_pkg::BYTE_SEL_BIT]) begin
                            nxt_st.operand = latch_snap[15:8];
                        end else begin
                            nxt_st.operand = latch_snap[7:0];
                        end
                    end
                    default: nxt_st.operand = add_latch_pkg::BYTE_ZERO;
                endcase
            end
            add_latch_pkg::PH_PROCESS: begin
                nxt_st.phase = add_latch_pkg::PH_WRITE;
                if (st_ff.op == add_latch_pkg::OP_LATCH_RD) begin
                    nxt_st.result = st_ff.operand;
                end else begin
                    // Carry is dropped on purpose; flags live elsewhere in the core.
                    nxt_st.result = 8'(st_ff.acc + st_ff.operand);
                end
            end
            add_latch_pkg::PH_WRITE: begin
                nxt_st.phase = add_latch_pkg::PH_DECODE;
                nxt_st.done = (st_ff.op != add_latch_pkg::OP_NONE);
                case (st_ff.op)
                    add_latch_pkg::OP_ADD_LIT: nxt_st.acc = st_ff.result;
                    add_latch_pkg::OP_ADD_REG: begin
                        if (st_ff.word[add_latch_pkg::DEST_BIT]) begin
                            nxt_st.file.wr_en = 1'b1;
                            nxt_st.file.wdata = st_ff.result;
                        end else begin
                            nxt_st.acc = st_ff.result;
                        end
                    end
                    add_latch_pkg::OP_LATCH_RD: begin
                        nxt_st.file.wr_en = 1'b1;
                        nxt_st.file.wdata = st_ff.result;
                    end
                    default: nxt_st.acc = st_ff.acc;
                endcase
            end
            default: nxt_st.phase = add_latch_pkg::PH_DECODE;
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_ff <= '{phase: add_latch_pkg::PH_DECODE, op: add_latch_pkg::OP_NONE,
                       word: add_latch_pkg::WORD_ZERO, operand: add_latch_pkg::BYTE_ZERO,
                       result: add_latch_pkg::BYTE_ZERO, acc: add_latch_pkg::BYTE_ZERO,
                       file: '0, done: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign file_req = st_ff.file;
    assign working_accumulator = st_ff.acc;
    assign op_done = st_ff.done;

endmodule : add_and_latch_read_datapath

// file: src/add_latch_pkg.sv
package add_latch_pkg;

    // ==========================================================
    // Opcode fields
    // ==========================================================
    localparam logic [7:0] OPC_ADD_LITERAL = 8'h00_b1;
    localparam logic [6:0] OPC_ADD_REGISTER = 7'h07;
    localparam logic [5:0] OPC_LATCH_READ = 6'h28;
    localparam int DEST_BIT = 8;
    localparam int BYTE_SEL_BIT = 9;
    localparam logic [7:0] BYTE_ZERO = 8'h00_00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ==========================================================
    // Instruction phases
    // ==========================================================
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b11,
        PH_WRITE = 2'b10
    } phase_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_ADD_LIT = 2'b01,
        OP_ADD_REG = 2'b11,
        OP_LATCH_RD = 2'b10
    } op_t;

    // Request from the decoder.
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } instr_t;

    // File register array access.
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } file_req_t;

    typedef struct packed {
        phase_t phase;
        op_t op;
        logic [15:0] word;
        logic [7:0] operand;
        logic [7:0] result;
        logic [7:0] acc;
        file_req_t file;
        logic done;
    } state_t;

endpackage : add_latch_pkg

// file: bench/add_latch_sva.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker of the add and latch-read datapath
// ==========================================================
module add_latch_sva (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Watched ports.
    input wire add_latch_pkg::instr_t instr,
    input wire logic instr_ready,
    input wire logic [15:0] table_latch,
    input wire add_latch_pkg::file_req_t file_req,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] working_accumulator,
    input wire logic op_done
);
    logic take, lit, reg_op, lrd;
    logic [7:0] acc;
    // Operation taken this cycle; the figures below count from this edge.
    assign take = instr.valid && instr_ready;
    assign lit = take && instr.word[15:8] == add_latch_pkg::OPC_ADD_LITERAL;
    assign reg_op = take && instr.word[15:9] == add_latch_pkg::OPC_ADD_REGISTER;
    assign lrd = take && instr.word[15:10] == add_latch_pkg::OPC_LATCH_READ;
    assign acc = working_accumulator;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    chk_lit_sum: assert property (lit |-> ##4 acc == $past(acc) + $past(instr.word[7:0], 4))
        else $error("literal sum wrong");
    chk_lit_nowr: assert property (lit |-> ##4 !file_req.wr_en)
        else $error("literal add wrote the array");
    chk_reg_acc: assert property (reg_op && !instr.word[8] |-> ##4 acc == $past(acc) + $past(file_rdata, 3))
        else $error("register add to accumulator wrong");
    chk_reg_back: assert property (reg_op && instr.word[8] |-> ##4 file_req.wr_en && $stable(acc)
        && file_req.wdata == $past(acc) + $past(file_rdata, 3))
        else $error("register write-back wrong");
    chk_latch_byte: assert property (lrd |-> ##4 file_req.wr_en && file_req.addr == $past(instr.word[7:0], 4)
        && file_req.wdata == ($past(instr.word[9], 4) ? $past(table_latch[15:8], 3) : $past(table_latch[7:0], 3)))
        else $error("latch byte write wrong");
    chk_latch_acc: assert property (lrd |=> $stable(acc) [*4])
        else $error("latch read moved the accumulator");
    chk_four_phase: assert property (take |=> !instr_ready [*3] ##1 (instr_ready && op_done))
        else $error("operation not four cycles");
    chk_rd_addr: assert property (reg_op |=> file_req.rd_en && file_req.addr == $past(instr.word[7:0]))
        else $error("file read request wrong");
    cover property (lit);
    cover property (lrd && instr.word[9]);
    cover property (reg_op && instr.word[8]);
endmodule : add_latch_sva
bind add_and_latch_read_datapath add_latch_sva add_latch_sva_inst (.*);

// file: bench/file_reg_model.sv
`timescale 1ns/100ps
// ==========================================================
// File register array facing the datapath
// ==========================================================
module file_reg_model (
    // Clock.
    input wire logic mclk,
    // Array access.
    input wire add_latch_pkg::file_req_t file_req,
    output logic [7:0] file_rdata
);
    logic [7:0] mem [256];
    // Answers within the read cycle; inverted data otherwise so stale bytes never pass.
    assign file_rdata = file_req.rd_en ? mem[file_req.addr] : ~mem[file_req.addr];
    // Writes land at the edge that sees the strobe.
    always @(posedge mclk) begin
        if (file_req.wr_en) begin
            mem[file_req.addr] <= file_req.wdata;
        end
    end
endmodule : file_reg_model

// file: bench/add_and_latch_read_datapath_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module add_and_latch_read_datapath_tb_top;
    logic mclk = 0, srst = 1, instr_ready, op_done;
    add_latch_pkg::instr_t instr = '0;
    add_latch_pkg::file_req_t file_req;
    logic [15:0] table_latch = 16'h0000;
    logic [7:0] file_rdata, working_accumulator;
    int error_cnt = 0, n_compared = 0, k;
    // Rows: word, latch, accumulator after, write strobe, byte written.
    logic [48:0] rows [7] = '{{16'hb115, 16'h0000, 8'h15, 1'b0, 8'h00},
        {16'h0e10, 16'h0000, 8'hd7, 1'b0, 8'h00}, {16'h0f20, 16'h0000, 8'hd7, 1'b1, 8'hee},
        {16'ha030, 16'h00af, 8'hd7, 1'b1, 8'haf}, {16'ha231, 16'h5aaf, 8'hd7, 1'b1, 8'h5a},
        {16'hb1ff, 16'h5aaf, 8'hd6, 1'b0, 8'h00}, {16'h0e20, 16'h5aaf, 8'hc4, 1'b0, 8'h00}};
    add_and_latch_read_datapath add_and_latch_read_datapath_inst (.*);
    file_reg_model file_reg_model_inst (.*);
    initial begin
        forever #2 mclk = ~mclk;
    end
    // Single exit point, used by the main sequence and by any timeout.
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        file_reg_model_inst.mem[8'h10] = 8'hc2;
        file_reg_model_inst.mem[8'h20] = 8'h17;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK("acc reset", 8'h00, working_accumulator)
        foreach (rows[i]) begin
            @(posedge mclk);
            instr <= {1'b1, rows[i][48:33]};
            table_latch <= rows[i][32:17];
            @(posedge mclk);
            instr.valid <= 1'b0;
            for (k = 0; k < 9 && op_done !== 1'b1; k++) begin
                @(posedge mclk);
                #1;
            end
            if (op_done !== 1'b1) begin
                error_cnt++;
                wrap_up();
            end
            `CHK("acc", rows[i][16:9], working_accumulator)
            `CHK("wr_en", rows[i][8], file_req.wr_en)
            if (rows[i][8]) `CHK("wdata", rows[i][7:0], file_req.wdata)
        end
        // Reset in mid-operation must abandon the add.
        @(posedge mclk);
        instr <= {1'b1, 16'hb101};
        @(posedge mclk);
        instr.valid <= 1'b0;
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        `CHK("acc after reset", 8'h00, working_accumulator)
        `CHK("ready after reset", 1'b1, instr_ready)
        wrap_up();
    end
endmodule : add_and_latch_read_datapath_tb_top
